// File: bench/i2c_master_model.sv
/*
 Two-wire bus master model: makes the serial clock, frames starts and
 stops, and moves bytes over the open-drain data line.
 Assumes a pulled-up wire; the bench calls the tasks hierarchically.
*/
module i2c_master_model
(
   input  wire logic i_ref_clk,
   input  wire logic i_sda,
   output logic      o_scl,
   output logic      o_sda_low
);
   timeunit 1ns;
   timeprecision 1ps;
   localparam int Q = 25;  // Quarter bit time in clocks

   // Idle bus: clock high, data released
   initial
   begin
      o_scl = 1'h1;
      o_sda_low = 1'h0;
   end

   // Wait n quarter bit times
   task automatic wait_q(input int n);
      repeat (n * Q) @(posedge i_ref_clk);
   endtask : wait_q

   // Data falls while the clock is high
   task automatic start_cond();
      o_sda_low <= 1'h0;
      wait_q(1);
      o_scl <= 1'h1;
      wait_q(1);
      o_sda_low <= 1'h1;
      wait_q(1);
      o_scl <= 1'h0;
      wait_q(1);
   endtask : start_cond

   // Data rises while the clock is high, then bus free time
   task automatic stop_cond();
      o_sda_low <= 1'h1;
      wait_q(1);
      o_scl <= 1'h1;
      wait_q(1);
      o_sda_low <= 1'h0;
      wait_q(2);
   endtask : stop_cond

   // One clock: data set while low, read back while high
   task automatic bit_io(input logic b, output logic r);
      o_sda_low <= !b;
      wait_q(1);
      o_scl <= 1'h1;
      wait_q(1);
      r = i_sda;
      wait_q(1);
      o_scl <= 1'h0;
      wait_q(1);
   endtask : bit_io

   // Byte out MSB first, then release for the ninth clock
   task automatic byte_out(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--)
         bit_io(d[i], r);
      bit_io(1'h1, r);
      ack = !r;
   endtask : byte_out

   // Byte in MSB first, then acknowledge or decline
   task automatic byte_in(input logic ack, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--)
      begin
         bit_io(1'h1, r);
         d[i] = r;
      end
      bit_io(!ack, r);
   endtask : byte_in

   // Short 80 ns spike on the clock while it is low
   task automatic glitch();
      o_scl <= 1'h1;
      repeat (8) @(posedge i_ref_clk);
      o_scl <= 1'h0;
      wait_q(1);
   endtask : glitch
endmodule : i2c_master_model

// File: bench/tb_serial_eeprom_bus_slave.sv
/*
 Self-checking bench of the EEPROM bus slave front end.
 Assumes the master model is compiled first; stream drained on link clock.
*/
module tb_serial_eeprom_bus_slave;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int PU = 50;          // Shortened power-up count
   localparam int PG = 2000;        // Shortened program count
   localparam int LIMIT = 80000;    // Cycle ceiling of the run
   localparam logic [7:0] SLV_W = 8'hAA; // Prefix, straps 101, write
   logic       ref_clk = 1'h0;
   logic       link_clk = 1'h0;
   logic       reset_n, supply_ok, wp, ready_en, wr_ready, scl, m_low;
   logic       sda_out, sda_oe, rd_next, commit, busy, wr_valid, wr_first;
   logic [2:0] strap;
   logic [7:0] rd_data, wr_data;
   logic [8:0] q[$];                // Words seen on the stream
   int         failures, n_compared, commits, cycles;
   wire        sda_line = !(m_low || sda_oe); // Pulled-up wired AND

   i2c_master_model master (.i_ref_clk(ref_clk), .i_sda(sda_line), .o_scl(scl),
      .o_sda_low(m_low));
   eeprom_bus_slave #(.POWERUP_CYCLES(PU), .PROGRAM_CYCLES(PG)) dut (
      .i_ref_clk(ref_clk), .i_reset_n(reset_n), .i_link_clk(link_clk),
      .i_supply_ok(supply_ok), .i_scl(scl), .i_sda_in(sda_line), .o_sda_out(sda_out),
      .o_sda_oe(sda_oe), .i_device_select_bit0(strap[0]), .i_device_select_bit1(strap[1]),
      .i_device_select_bit2(strap[2]), .i_write_protect(wp), .i_rd_data(rd_data),
      .o_rd_next(rd_next), .o_commit(commit), .o_busy(busy), .o_wr_valid(wr_valid),
      .o_wr_data(wr_data), .o_wr_first(wr_first), .i_wr_ready(wr_ready));

   // Clocks, the link one offset in phase
   always #5 ref_clk = ~ref_clk;
   initial
   begin
      #3;
      forever #40 link_clk = ~link_clk;
   end

   // Stream consumer, stalled by ready_en
   always @(posedge link_clk)
   begin
      wr_ready <= ready_en;
      if (wr_valid && wr_ready)
         q.push_back({wr_first, wr_data});
   end

   // Read source, commit counter, pin watch, timeout
   always @(posedge ref_clk)
   begin
      if (rd_next)
         rd_data <= ~rd_data;
      if (commit)
         commits++;
      if (sda_oe === 1'h1)
         check("sda_out", {15'h0, sda_out}, 16'h0000);
      cycles++;
      if (cycles == LIMIT)
      begin
         failures++;
         report_and_stop();
      end
   end

   // Compare and count
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         failures++;
         $display("Error %s: expected %0h, seen %0h", what, exp, seen);
      end
   endtask : check

   // Send a byte and judge the acknowledge
   task automatic send(input string what, input logic [7:0] d, input logic exp);
      logic a;
      master.byte_out(d, a);
      check(what, {15'h0, a}, {15'h0, exp});
   endtask : send

   // Quiet before supply, then power up
   task automatic t_reset();
      check("oe_rst", {15'h0, sda_oe}, 16'h0000);
      check("busy_rst", {15'h0, busy}, 16'h0000);
      check("valid_rst", {15'h0, wr_valid}, 16'h0000);
      master.start_cond();
      send("unpowered", SLV_W, 1'h0);
      master.stop_cond();
      supply_ok <= 1'h1;
      repeat (PU + 20) @(posedge ref_clk);
   endtask : t_reset

   // Byte write with a clock spike, stream contents
   task automatic t_write();
      int c0 = commits;
      master.start_cond();
      send("slave_w", SLV_W, 1'h1);
      send("addr_hi", 8'h01, 1'h1);
      master.glitch();
      send("addr_lo", 8'h23, 1'h1);
      send("data", 8'h9C, 1'h1);
      master.stop_cond();
      check("commit", 16'(commits), 16'(c0 + 1));
      check("busy", {15'h0, busy}, 16'h0001);
      for (int i = 0; i < 2000 && q.size() < 3; i++) @(posedge ref_clk);
      check("w0", {7'h0, q[0]}, 16'h0101);
      check("w1", {7'h0, q[1]}, 16'h0023);
      check("w2", {7'h0, q[2]}, 16'h009C);
      q.delete();
   endtask : t_write

   // Polling during the program cycle
   task automatic t_poll();
      master.start_cond();
      send("poll", SLV_W, 1'h0);
      master.stop_cond();
      for (int i = 0; i < PG && busy; i++) @(posedge ref_clk);
      check("busy_end", {15'h0, busy}, 16'h0000);
   endtask : t_poll

   // Every device-select code against straps 101, and a wrong prefix
   task automatic t_straps();
      for (int k = 0; k < 8; k++)
      begin
         master.start_cond();
         send("strap", {4'hA, 3'(k), 1'h0}, k == 5);
         master.stop_cond();
      end
      master.start_cond();
      send("prefix", 8'hBA, 1'h0);
      master.stop_cond();
   endtask : t_straps

   // Write protect rejects the data byte
   task automatic t_protect();
      int c0 = commits;
      wp <= 1'h1;
      master.start_cond();
      send("slave_p", SLV_W, 1'h1);
      send("hi_p", 8'h01, 1'h1);
      send("lo_p", 8'h02, 1'h1);
      send("data_p", 8'h03, 1'h0);
      master.stop_cond();
      check("commit_p", 16'(commits), 16'(c0));
      check("busy_p", {15'h0, busy}, 16'h0000);
      wp <= 1'h0;
      repeat (200) @(posedge ref_clk);
      q.delete();
   endtask : t_protect

   // Two read bytes, acknowledged then declined
   task automatic t_read();
      logic [7:0] d;
      master.start_cond();
      send("slave_r", 8'hAB, 1'h1);
      master.byte_in(1'h1, d);
      check("rd0", {8'h0, d}, 16'h005A);
      master.byte_in(1'h0, d);
      check("rd1", {8'h0, d}, 16'h00A5);
      master.stop_cond();
   endtask : t_read

   // Supply dip in mid-command drops it
   task automatic t_brownout();
      master.start_cond();
      send("slave_b", SLV_W, 1'h1);
      supply_ok <= 1'h0;
      repeat (20) @(posedge ref_clk);
      check("oe_dip", {15'h0, sda_oe}, 16'h0000);
      supply_ok <= 1'h1;
      repeat (PU + 20) @(posedge ref_clk);
      send("dropped", 8'h01, 1'h0);
      master.stop_cond();
   endtask : t_brownout

   // Stalled stream fills the buffer, then drains
   task automatic t_full();
      int c0 = commits;
      int acks = 0;
      logic a;
      ready_en <= 1'h0;
      master.start_cond();
      send("slave_f", SLV_W, 1'h1);
      for (int i = 0; i < 22; i++)
      begin
         master.byte_out(8'(i), a);
         if (i < 16)
            check("fill", {15'h0, a}, 16'h0001);
         acks += a;
      end
      check("full", {15'h0, a}, 16'h0000);
      master.stop_cond();
      check("commit_f", 16'(commits), 16'(c0));
      ready_en <= 1'h1;
      for (int i = 0; i < 3000 && q.size() < acks; i++) @(posedge ref_clk);
      repeat (100) @(posedge ref_clk);
      check("drained", 16'(q.size()), 16'(acks));
      check("valid_end", {15'h0, wr_valid}, 16'h0000);
   endtask : t_full

   // Counts and verdict
   task automatic report_and_stop();
      $display("Compared %0d, failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : report_and_stop

   // Main sequence
   initial
   begin
      reset_n = 1'h0;
      supply_ok = 1'h0;
      wp = 1'h0;
      ready_en = 1'h1;
      wr_ready = 1'h0;
      strap = 3'h5;
      rd_data = 8'h5A;
      repeat (3) @(posedge ref_clk);
      reset_n <= 1'h1;
      t_reset();
      t_write();
      t_poll();
      t_straps();
      t_protect();
      t_read();
      t_brownout();
      t_full();
      report_and_stop();
   end
endmodule : tb_serial_eeprom_bus_slave

// File: hw/byte_fifo.sv
/*
 Small synchronous FIFO with a registered output stage.
 Assumes one clock and an active-low asynchronous reset.
*/
module byte_fifo #(
   parameter int WIDTH = 9,
   parameter int DEPTH = 16
) (
   input  wire logic             i_ref_clk,
   input  wire logic             i_reset_n,
   input  wire logic             i_in_valid,
   output logic                  o_in_ready,
   input  wire logic [WIDTH-1:0] i_in_data,
   output logic                  o_out_valid,
   input  wire logic             i_out_ready,
   output logic      [WIDTH-1:0] o_out_data
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];  // Storage
   logic [AW-1:0]    wr_ptr;       // Write slot
   logic [AW-1:0]    rd_ptr;       // Read slot
   logic [AW:0]      count;        // Words in storage
   logic             out_valid;    // Output register holds a word

   wire push = i_in_valid && o_in_ready;
   wire load = (count != '0) && (!out_valid || i_out_ready);

   assign o_in_ready = (count != (AW+1)'(DEPTH));
   assign o_out_valid = out_valid;

   // Storage write
   always_ff @(posedge i_ref_clk)
   begin
      if (push)
      begin
         mem[wr_ptr] <= i_in_data;
      end
   end

   // Pointers, count and output register
   always_ff @(posedge i_ref_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
         out_valid <= 1'h0;
         o_out_data <= '0;
      end
      else
      begin
         if (push)
            wr_ptr <= wr_ptr + 1'h1;
         if (load)
         begin
            rd_ptr <= rd_ptr + 1'h1;
            o_out_data <= mem[rd_ptr];
            out_valid <= 1'h1;
         end
         else if (i_out_ready)
            out_valid <= 1'h0;
         count <= count + (AW+1)'(push) - (AW+1)'(load);
      end
   end
endmodule : byte_fifo

// File: hw/eeprom_bus_slave.sv
/*
 Two-wire bus slave front end of a serial EEPROM: pin sync, glitch
 filter, power-on sequencing, address match, acknowledge, write protect,
 write stream out through a FIFO into the link clock domain.
 Assumes the serial clock and data pins, straps and supply monitor are
 asynchronous; read bytes come from same-clock logic on i_rd_data.
*/
module eeprom_bus_slave #(
   parameter int POWERUP_CYCLES = eeprom_slave_pkg::POWERUP_CYCLES,
   parameter int PROGRAM_CYCLES = eeprom_slave_pkg::PROGRAM_CYCLES
) (
   input  wire logic       i_ref_clk,
   input  wire logic       i_reset_n,
   input  wire logic       i_link_clk,
   input  wire logic       i_supply_ok,
   input  wire logic       i_scl,
   input  wire logic       i_sda_in,
   output logic            o_sda_out,
   output logic            o_sda_oe,
   input  wire logic       i_device_select_bit0,
   input  wire logic       i_device_select_bit1,
   input  wire logic       i_device_select_bit2,
   input  wire logic       i_write_protect,
   input  wire logic [7:0] i_rd_data,
   output logic            o_rd_next,
   output logic            o_commit,
   output logic            o_busy,
   output logic            o_wr_valid,
   output logic [7:0]      o_wr_data,
   output logic            o_wr_first,
   input  wire logic       i_wr_ready
);
   localparam int TB = eeprom_slave_pkg::TIMER_BITS;

   // Pin synchronisers: {supply, wp, sel2, sel1, sel0, scl, sda}
   logic [6:0]      pin_s1;
   logic [6:0]      pin_s2;
   // Glitch filters, index 1 = clock, 0 = data
   logic [1:0]      flt;
   logic [1:0]      flt_d;
   logic [3:0]      fcnt [2];
   // Power sequencing
   logic [TB-1:0]   pu_cnt;
   logic            ready;
   // Program cycle timer
   logic [TB-1:0]   prog_cnt;
   // Bus engine
   eeprom_slave_pkg::bus_state_type state;
   logic [3:0]      bit_cnt;
   logic [7:0]      shreg;
   logic [1:0]      byte_idx;
   logic            is_read;
   logic            wp_lat;
   logic            rejected;
   logic            got_data;
   logic            ack_ok;
   logic            master_ack;
   // Crossing into the link domain
   logic [8:0]      xfer_word;
   logic            req_tgl;
   logic            ack_s1;
   logic            ack_s2;
   logic            req_s1;
   logic            req_s2;
   logic            req_seen;
   logic            link_pending;
   logic            ack_tgl;
   // FIFO wiring
   logic            fifo_in_ready;
   logic            fifo_out_valid;
   logic [8:0]      fifo_out_data;

   // Named views of the synchronised pins; straps reset low
   wire       powered = pin_s2[6];
   wire       wp_s = pin_s2[5];
   wire [2:0] dev_sel = pin_s2[4:2];
   wire       scl = flt[1];
   wire       sda = flt[0];
   // Bus events from filtered lines
   wire scl_rise = scl && !flt_d[1];
   wire scl_fall = !scl && flt_d[1];
   wire start_det = scl && flt_d[1] && flt_d[0] && !sda;
   wire stop_det = scl && flt_d[1] && !flt_d[0] && sda;
   // Decode
   wire addr_match = (shreg[7:4] == eeprom_slave_pkg::DEVICE_PREFIX)
                  && (shreg[3:1] == dev_sel);
   wire data_byte = (byte_idx == eeprom_slave_pkg::IDX_DATA);
   wire byte_done = scl_fall && (bit_cnt == eeprom_slave_pkg::BYTE_BITS);
   wire rx_ack = (state == eeprom_slave_pkg::ST_ADDR) ? addr_match
               : fifo_in_ready && !(data_byte && wp_lat);
   wire push = (state == eeprom_slave_pkg::ST_RX) && byte_done && rx_ack;
   wire load_tx = (state == eeprom_slave_pkg::ST_ACK) && scl_fall && ack_ok && is_read;
   wire reload_tx = (state == eeprom_slave_pkg::ST_RXACK) && scl_fall && master_ack;
   wire busy = (prog_cnt != '0);
   wire xfer_free = (req_tgl == ack_s2);

   // Line is only ever pulled low
   assign o_sda_out = 1'h0;
   assign o_busy = busy;
   assign o_wr_valid = link_pending;

   // Two-flop synchronisers for every pin
   always_ff @(posedge i_ref_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         pin_s1 <= 7'h00;
         pin_s2 <= 7'h00;
      end
      else
      begin
         pin_s1 <= {i_supply_ok, i_write_protect, i_device_select_bit2,
                    i_device_select_bit1, i_device_select_bit0, i_scl, i_sda_in};
         pin_s2 <= pin_s1;
      end
   end

   // Glitch filters: new level must outlast the filter width
   always_ff @(posedge i_ref_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         flt <= 2'h3;
         flt_d <= 2'h3;
         fcnt[0] <= 4'h0;
         fcnt[1] <= 4'h0;
      end
      else
      begin
         flt_d <= flt;
         for (int i = 0; i < 2; i++)
         begin
            if (pin_s2[i] == flt[i])
               fcnt[i] <= 4'h0;
            else if (fcnt[i] == eeprom_slave_pkg::GLITCH_CYCLES)
            begin
               flt[i] <= pin_s2[i];
               fcnt[i] <= 4'h0;
            end
            else
               fcnt[i] <= fcnt[i] + 4'h1;
         end
      end
   end

   // Power-up delay and brown-out reset
   always_ff @(posedge i_ref_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         pu_cnt <= '0;
         ready <= 1'h0;
      end
      else if (!powered)
      begin
         pu_cnt <= '0;
         ready <= 1'h0;
      end
      else if (!ready)
      begin
         pu_cnt <= pu_cnt + 1'h1;
         ready <= (pu_cnt == TB'(POWERUP_CYCLES - 1));
      end
   end

   // Internal program cycle timer
   always_ff @(posedge i_ref_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
         prog_cnt <= '0;
      else if (!ready)
         prog_cnt <= '0;
      else if (o_commit)
         prog_cnt <= TB'(PROGRAM_CYCLES);
      else if (busy)
         prog_cnt <= prog_cnt - 1'h1;
   end

   // Bus engine
   always_ff @(posedge i_ref_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         state <= eeprom_slave_pkg::ST_RESET;
         bit_cnt <= 4'h0;
         shreg <= 8'h00;
         byte_idx <= 2'h0;
         is_read <= 1'h0;
         wp_lat <= 1'h0;
         rejected <= 1'h0;
         got_data <= 1'h0;
         ack_ok <= 1'h0;
         master_ack <= 1'h0;
         o_sda_oe <= 1'h0;
         o_rd_next <= 1'h0;
         o_commit <= 1'h0;
      end
      else
      begin
         o_rd_next <= load_tx || reload_tx;
         o_commit <= 1'h0;
         if (!ready)
         begin
            // Drop any partial command, keep line released
            state <= eeprom_slave_pkg::ST_RESET;
            o_sda_oe <= 1'h0;
            got_data <= 1'h0;
         end
         else if (state == eeprom_slave_pkg::ST_RESET)
            state <= eeprom_slave_pkg::ST_IDLE;
         else if (stop_det)
         begin
            // Stop launches the program cycle for an accepted write
            o_commit <= !is_read && got_data && !rejected;
            state <= eeprom_slave_pkg::ST_IDLE;
            o_sda_oe <= 1'h0;
            got_data <= 1'h0;
         end
         else if (start_det)
         begin
            // Ignored while programming so the master can poll
            state <= busy ? eeprom_slave_pkg::ST_IDLE
                          : eeprom_slave_pkg::ST_ADDR;
            bit_cnt <= 4'h0;
            byte_idx <= eeprom_slave_pkg::IDX_SLAVE;
            o_sda_oe <= 1'h0;
            rejected <= 1'h0;
            got_data <= 1'h0;
         end
         else
         begin
            case (state)
               eeprom_slave_pkg::ST_ADDR,
               eeprom_slave_pkg::ST_RX:
               begin
                  // Shift in on rise; decide answer on eighth fall
                  if (scl_rise)
                  begin
                     shreg <= {shreg[6:0], sda};
                     bit_cnt <= bit_cnt + 4'h1;
                  end
                  if (byte_done)
                  begin
                     o_sda_oe <= rx_ack;
                     ack_ok <= rx_ack;
                     state <= eeprom_slave_pkg::ST_ACK;
                     if (state == eeprom_slave_pkg::ST_ADDR)
                        is_read <= shreg[0];
                     if (data_byte && !rx_ack)
                        rejected <= 1'h1;
                     if (data_byte && rx_ack)
                        got_data <= 1'h1;
                  end
               end
               eeprom_slave_pkg::ST_ACK:
               begin
                  // End of the ninth clock
                  if (scl_fall)
                  begin
                     bit_cnt <= 4'h0;
                     if (byte_idx == eeprom_slave_pkg::IDX_ADDR_LO)
                        wp_lat <= wp_s;
                     if (!data_byte)
                        byte_idx <= byte_idx + 2'h1;
                     if (!ack_ok)
                     begin
                        o_sda_oe <= 1'h0;
                        state <= eeprom_slave_pkg::ST_IDLE;
                     end
                     else if (is_read)
                     begin
                        shreg <= i_rd_data;
                        o_sda_oe <= !i_rd_data[7];
                        state <= eeprom_slave_pkg::ST_TX;
                     end
                     else
                     begin
                        o_sda_oe <= 1'h0;
                        state <= eeprom_slave_pkg::ST_RX;
                     end
                  end
               end
               eeprom_slave_pkg::ST_TX:
               begin
                  // Next bit after each fall; release after the eighth
                  if (scl_fall)
                  begin
                     if (bit_cnt == eeprom_slave_pkg::LAST_TX_BIT)
                     begin
                        o_sda_oe <= 1'h0;
                        state <= eeprom_slave_pkg::ST_RXACK;
                     end
                     else
                     begin
                        o_sda_oe <= !shreg[6];
                        shreg <= {shreg[6:0], 1'h0};
                        bit_cnt <= bit_cnt + 4'h1;
                     end
                  end
               end
               eeprom_slave_pkg::ST_RXACK:
               begin
                  // Master acks low to continue reading
                  if (scl_rise)
                     master_ack <= !sda;
                  if (scl_fall)
                  begin
                     bit_cnt <= 4'h0;
                     if (master_ack)
                     begin
                        shreg <= i_rd_data;
                        o_sda_oe <= !i_rd_data[7];
                        state <= eeprom_slave_pkg::ST_TX;
                     end
                     else
                        state <= eeprom_slave_pkg::ST_IDLE;
                  end
               end
               default:
                  o_sda_oe <= 1'h0;
            endcase
         end
      end
   end

   // Write stream buffer; full FIFO makes the slave decline bytes
   byte_fifo #(
      .WIDTH (eeprom_slave_pkg::FIFO_WIDTH),
      .DEPTH (eeprom_slave_pkg::FIFO_DEPTH)
   ) u_fifo (
      .i_ref_clk   (i_ref_clk),
      .i_reset_n   (i_reset_n),
      .i_in_valid  (push),
      .o_in_ready  (fifo_in_ready),
      .i_in_data   ({byte_idx == eeprom_slave_pkg::IDX_ADDR_HI, shreg}),
      .o_out_valid (fifo_out_valid),
      .i_out_ready (xfer_free),
      .o_out_data  (fifo_out_data)
   );

   // Reference side of the toggle handshake
   always_ff @(posedge i_ref_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         xfer_word <= 9'h000;
         req_tgl <= 1'b0;
         ack_s1 <= 1'b0;
         ack_s2 <= 1'b0;
      end
      else
      begin
         ack_s1 <= ack_tgl;
         ack_s2 <= ack_s1;
         if (fifo_out_valid && xfer_free)
         begin
            xfer_word <= fifo_out_data;
            req_tgl <= !req_tgl;
         end
      end
   end

   // Link side: word held stable while the request toggle is pending
   always_ff @(posedge i_link_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         req_s1 <= 1'b0;
         req_s2 <= 1'b0;
         req_seen <= 1'b0;
         link_pending <= 1'b0;
         ack_tgl <= 1'b0;
         o_wr_data <= 8'h00;
         o_wr_first <= 1'b0;
      end
      else
      begin
         req_s1 <= req_tgl;
         req_s2 <= req_s1;
         if (!link_pending && (req_s2 != req_seen))
         begin
            {o_wr_first, o_wr_data} <= xfer_word;
            req_seen <= req_s2;
            link_pending <= 1'b1;
         end
         else if (link_pending && i_wr_ready)
         begin
            link_pending <= 1'b0;
            ack_tgl <= req_seen;
         end
      end
   end

   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (!i_reset_n);

   sequence s_nack_end;
      (state == eeprom_slave_pkg::ST_ACK) && scl_fall && !ack_ok;
   endsequence

   a_drive_on_fall: assert property ($rose(o_sda_oe) |-> $past(scl_fall))
      else $error("data line driven outside a clock fall");
   a_addr_mismatch: assert property ((state == eeprom_slave_pkg::ST_ADDR) && byte_done
      && !addr_match |=> !o_sda_oe [*2])
      else $error("acknowledged a foreign address");
   a_wp_blocks: assert property ((state == eeprom_slave_pkg::ST_RX) && byte_done
      && data_byte && wp_lat |=> !o_sda_oe && rejected)
      else $error("data byte accepted under write protect");
   a_glitch_width: assert property ($changed(scl) |->
      $past(fcnt[1]) == eeprom_slave_pkg::GLITCH_CYCLES)
      else $error("clock level accepted before filter width");
   a_ready_delay: assert property ($rose(ready) |->
      $past(pu_cnt) == TB'(POWERUP_CYCLES - 1))
      else $error("ready at wrong time after power-up");
   a_brownout_reset: assert property (!powered |=> !ready ##1
      state == eeprom_slave_pkg::ST_RESET)
      else $error("supply loss did not reset the engine");
   a_busy_quiet: assert property (busy |-> !o_sda_oe)
      else $error("line driven during program cycle");
   a_nack_release: assert property (s_nack_end |=>
      (state == eeprom_slave_pkg::ST_IDLE) && !o_sda_oe)
      else $error("line not released after declined byte");
   a_reset_release: assert property (!ready |=> !o_sda_oe)
      else $error("line driven while in reset mode");
   a_commit_timer: assert property (o_commit |=> busy ##1 busy)
      else $error("program cycle did not start on commit");
endmodule : eeprom_bus_slave

// File: include/eeprom_slave_pkg.sv
/*
 Constants shared by the two-wire EEPROM slave front end and its FIFO.
 Assumes a 100 MHz reference clock; all timing counts derive from it.
*/
package eeprom_slave_pkg;
   // Reference clock period
   localparam int REF_CLK_NS = 10;
   // Widest bus pulse that must be ignored
   localparam int GLITCH_FILTER_WIDTH_NS = 100;
   // Samples a new level is allowed to be short-lived (rounded up)
   localparam int GLITCH_CYCLES_INT =
      (GLITCH_FILTER_WIDTH_NS + REF_CLK_NS - 1) / REF_CLK_NS;
   localparam logic [3:0] GLITCH_CYCLES = 4'(GLITCH_CYCLES_INT);
   // Ready delay after supply is stable (rounded down, a longest time)
   localparam int POWERUP_READY_DELAY_MS = 1;
   localparam int POWERUP_CYCLES = (POWERUP_READY_DELAY_MS * 1000000) / REF_CLK_NS;
   // Internal program (write) cycle
   localparam int INTERNAL_PROGRAM_TIME_MS = 5;
   localparam int PROGRAM_CYCLES = (INTERNAL_PROGRAM_TIME_MS * 1000000) / REF_CLK_NS;
   // Width of the long timers
   localparam int TIMER_BITS = 20;
   // Fixed upper nibble of the slave address
   localparam logic [3:0] DEVICE_PREFIX = 4'hA;
   // Bits per byte, counted on rising clock edges
   localparam logic [3:0] BYTE_BITS = 4'h8;
   // Last bit index during transmit
   localparam logic [3:0] LAST_TX_BIT = 4'h7;
   // Byte positions inside a command
   localparam logic [1:0] IDX_SLAVE = 2'h0;
   localparam logic [1:0] IDX_ADDR_HI = 2'h1;
   localparam logic [1:0] IDX_ADDR_LO = 2'h2;
   localparam logic [1:0] IDX_DATA = 2'h3;
   // Write stream FIFO shape: {first flag, byte}
   localparam int FIFO_WIDTH = 9;
   localparam int FIFO_DEPTH = 16;

   // Bus engine states
   typedef enum logic [2:0]
   {
      ST_RESET,
      ST_IDLE,
      ST_ADDR,
      ST_RX,
      ST_ACK,
      ST_TX,
      ST_RXACK
   } bus_state_type;
endpackage : eeprom_slave_pkg
